// ### logic/vbsr_pkg.sv
package vbsr_pkg;

  // Register byte offsets on the plain register port.
  localparam logic [7:0] ADDR_STEREO_ERR   = 8'h58;
  localparam logic [7:0] ADDR_SKEW_CTL     = 8'h59;
  localparam logic [7:0] ADDR_LINK_STS     = 8'h5A;
  localparam logic [7:0] ADDR_STEREO_MODE  = 8'h60;
  localparam logic [7:0] ADDR_WIDTH_LO     = 8'h61;
  localparam logic [7:0] ADDR_WIDTH_HI     = 8'h62;
  localparam logic [7:0] ADDR_IRQ_STS      = 8'h63;
  localparam logic [7:0] ADDR_IRQ_CLR      = 8'h64;
  localparam logic [7:0] ADDR_IRQ_EN       = 8'h65;
  localparam logic [7:0] ADDR_PORT_SEL     = 8'h66;

  // Reset values.
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [2:0]  RST_FLAGS = 3'h0;
  localparam logic [12:0] RST_WIDTH = 13'h0000;

  // Error flag bit positions in the stereo error register.
  localparam int FLAG_MISMATCH = 0;
  localparam int FLAG_PROC     = 1;
  localparam int FLAG_OVERFLOW = 2;

  // Line length limits and checks.
  localparam logic [13:0] LEN_LIMIT_ALT_LINE = 14'h1000;
  localparam logic [13:0] LEN_LIMIT_WIDE     = 14'h2000;
  localparam logic [13:0] LEN_MAX            = 14'h3FFF;
  localparam logic [13:0] LEN_ONE            = 14'h0001;
  localparam logic [2:0]  MIN_BLANK          = 3'h4;

  // Skew measurement range and input delay depth.
  localparam logic [1:0] SKEW_MAX  = 2'h3;
  localparam int         LAG_DEPTH = 3;
  localparam int         PIX_W     = 24;

  // Serial port mode codes.
  localparam logic [1:0] PMODE_DUAL  = 2'h0;
  localparam logic [1:0] PMODE_IDLE  = 2'h0;

  // Stereo processing modes.
  typedef enum logic [1:0] {
    VBSR_MODE_OFF      = 2'h0,
    VBSR_MODE_ALT_LINE = 2'h1,
    VBSR_MODE_SBS      = 2'h2,
    VBSR_MODE_ALT_PIX  = 2'h3
  } vbsr_mode_t;

  // One pixel of an input stream.
  typedef struct packed {
    logic             de;
    logic [PIX_W-1:0] data;
  } vbsr_pixel_t;

  // Status reported by one serial transmit port.
  typedef struct packed {
    logic       link_ready;
    logic       tx_active;
    logic       rx_locked;
    logic       input_valid;
    logic       mode_ok;
    logic [1:0] port_mode;
    logic       clk_detected;
    logic       pll_lock;
    logic       no_clock;
    logic       freq_stable;
  } vbsr_link_t;

endpackage

// ### logic/vbsr_status_regs.sv
// Strobed register access was left to the implementer.
`timescale 1ns/10ps
// Functional notes
// - Alternate-line mode: a line of 4096 or more pixels sets overflow flag.
// - Side-by-side or alternate-pixel mode: 8192 or more pixels sets overflow flag.
// - The three stereo error flags read out, then that read clears them.
// - Invalid line length or blanking during stereo processing sets processing error.
// - Alternate-line mode: odd and even line lengths differing sets mismatch flag.
// - Side-by-side mode: line length not twice image width sets mismatch flag; lines shorter than image width are not checked.
// - Bits 7-6 delay port 1 video by 0 to 3 pixel clocks.
// - Bits 5-4 delay port 0 video by 0 to 3 pixel clocks.
// - Dual-good reads one only with both inputs active and skew measurable.
// - Skew sign reads 0 when port 0 leads or equal, 1 when port 1 leads.
// - Bits 1-0 report skew magnitude in pixel clocks.
// - Bit 7 shows link ready for the selected serial port.
// - Bit 6 shows transmitter active, receiver locked, input valid, correct mode.
// - While transmit status is one, bits 5-4 report the port mode code.
// - In independent mode, per-port status follows the selected serial port.
// - Bit 3 mirrors clock detect of the selected port.
// - In independent mode, clock mode field selects the addressed serial port.
// - Bits 2-0 report PLL lock, no clock, and stable frequency.
module vbsr_status_regs (
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [7:0]           reg_rdata,
  output logic                      irq,
  input  wire vbsr_pkg::vbsr_pixel_t port0_pixel,
  input  wire vbsr_pkg::vbsr_pixel_t port1_pixel,
  input  wire logic                 port0_active,
  input  wire logic                 port1_active,
  output vbsr_pkg::vbsr_pixel_t     merged_port0,
  output vbsr_pkg::vbsr_pixel_t     merged_port1,
  input  wire vbsr_pkg::vbsr_link_t link_status_in [2]
);

  default clocking dflt_cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // Register state.
  logic [2:0]           err_flags_r;
  logic [1:0]           port0_input_lag_r;
  logic [1:0]           port1_input_lag_r;
  vbsr_pkg::vbsr_mode_t stereo_mode_r;
  logic [12:0]          image_width_setting_r;
  logic [2:0]           irq_sts_r;
  logic [2:0]           irq_en_r;
  logic [1:0]           clk_mode_r;
  logic                 indep_mode_r;
  logic [7:0]           rdata_r;
  logic                 irq_r;

  // Register port decode.
  wire wr_skew    = reg_wr && (reg_addr == vbsr_pkg::ADDR_SKEW_CTL);
  wire wr_mode    = reg_wr && (reg_addr == vbsr_pkg::ADDR_STEREO_MODE);
  wire wr_wlo     = reg_wr && (reg_addr == vbsr_pkg::ADDR_WIDTH_LO);
  wire wr_whi     = reg_wr && (reg_addr == vbsr_pkg::ADDR_WIDTH_HI);
  wire wr_irq_clr = reg_wr && (reg_addr == vbsr_pkg::ADDR_IRQ_CLR);
  wire wr_irq_en  = reg_wr && (reg_addr == vbsr_pkg::ADDR_IRQ_EN);
  wire wr_sel     = reg_wr && (reg_addr == vbsr_pkg::ADDR_PORT_SEL);
  wire rd_stereo  = reg_rd && (reg_addr == vbsr_pkg::ADDR_STEREO_ERR);

  // Port 0 stream line measurement.
  logic        de_prev_r;
  logic [13:0] line_len_r;
  logic [13:0] prev_len_r;
  logic        even_line_r;
  logic [2:0]  blank_cnt_r;
  logic        seen_line_r;

  // The checks watch the merged port 0 output, one clock behind the selected lag tap.
  wire        cur_de     = merged_port0.de;
  wire        line_start = cur_de && !de_prev_r;
  wire        line_end   = !cur_de && de_prev_r;
  wire [13:0] width_x2   = {image_width_setting_r, 1'b0};
  wire        mode_alt_line = (stereo_mode_r == vbsr_pkg::VBSR_MODE_ALT_LINE);
  wire        mode_sbs      = (stereo_mode_r == vbsr_pkg::VBSR_MODE_SBS);
  wire        mode_alt_pix  = (stereo_mode_r == vbsr_pkg::VBSR_MODE_ALT_PIX);
  wire        mode_on       = (stereo_mode_r != vbsr_pkg::VBSR_MODE_OFF);

  // Error events of the stereo line checks.
  wire ovf_alt_line = line_end && mode_alt_line && (line_len_r >= vbsr_pkg::LEN_LIMIT_ALT_LINE);
  wire ovf_wide     = line_end && (mode_sbs || mode_alt_pix) && (line_len_r >= vbsr_pkg::LEN_LIMIT_WIDE);
  wire short_blank  = line_start && seen_line_r && (blank_cnt_r < vbsr_pkg::MIN_BLANK);
  wire odd_pix_line = line_end && mode_alt_pix && line_len_r[0];
  wire proc_evt     = mode_on && (short_blank || odd_pix_line);
  wire mism_alt     = line_end && mode_alt_line && even_line_r && (line_len_r != prev_len_r);
  // Lines shorter than one image width are let through unchecked, as the hardware allows.
  wire mism_sbs     = line_end && mode_sbs && ({1'b0, image_width_setting_r} <= line_len_r)
                      && (line_len_r != width_x2);
  wire [2:0] stereo_evt = {ovf_alt_line || ovf_wide, proc_evt, mism_alt || mism_sbs};

  // A flag set by an event in the same cycle as the clearing read survives it.
  wire [2:0] err_flags_nxt = (err_flags_r & {3{!rd_stereo}}) | stereo_evt;

  // Line length counter saturates so that an endless line still trips the limit.
  wire [13:0] line_len_nxt = !cur_de ? line_len_r :
                             line_start ? vbsr_pkg::LEN_ONE :
                             (line_len_r == vbsr_pkg::LEN_MAX) ? line_len_r : line_len_r + vbsr_pkg::LEN_ONE;
  wire [2:0]  blank_nxt    = cur_de ? 3'h0 :
                             (blank_cnt_r == vbsr_pkg::MIN_BLANK) ? blank_cnt_r : blank_cnt_r + 3'h1;

  // Line measurement registers.
  always_ff @(posedge clk) begin
    if (srst) begin
      de_prev_r   <= 1'b0;
      line_len_r  <= 14'h0000;
      prev_len_r  <= 14'h0000;
      even_line_r <= 1'b0;
      blank_cnt_r <= 3'h0;
      seen_line_r <= 1'b0;
    end else begin
      de_prev_r   <= cur_de;
      line_len_r  <= line_len_nxt;
      blank_cnt_r <= blank_nxt;
      if (line_end) begin
        prev_len_r  <= line_len_r;
        even_line_r <= mode_alt_line && !even_line_r;
        seen_line_r <= 1'b1;
      end
    end
  end

  // Input lag lines: each port keeps three past pixels and a tap picks one.
  vbsr_pkg::vbsr_pixel_t lag_tap [2][vbsr_pkg::LAG_DEPTH+1];
  vbsr_pkg::vbsr_pixel_t port_in [2];
  logic [1:0]            port_lag [2];
  vbsr_pkg::vbsr_pixel_t lag_out [2];
  assign port_in[0]  = port0_pixel;
  assign port_in[1]  = port1_pixel;
  assign port_lag[0] = port0_input_lag_r;
  assign port_lag[1] = port1_input_lag_r;

  genvar p;
  genvar k;
  generate
    for (p = 0; p < 2; p++) begin : g_lag
      assign lag_tap[p][0] = port_in[p];
      for (k = 1; k <= vbsr_pkg::LAG_DEPTH; k++) begin : g_stage
        always_ff @(posedge clk) begin
          if (srst) begin
            lag_tap[p][k] <= '0;
          end else begin
            lag_tap[p][k] <= lag_tap[p][k-1];
          end
        end
      end
      assign lag_out[p] = lag_tap[p][port_lag[p]];
    end
  endgenerate

  // Merged outputs leave from flip-flops, one clock after the selected tap.
  always_ff @(posedge clk) begin
    if (srst) begin
      merged_port0 <= '0;
      merged_port1 <= '0;
    end else begin
      merged_port0 <= lag_out[0];
      merged_port1 <= lag_out[1];
    end
  end

  // Skew measurement on the raw inputs, before any lag is applied.
  typedef enum logic [1:0] {SK_IDLE, SK_P0_LEAD, SK_P1_LEAD} vbsr_skew_st_t;
  vbsr_skew_st_t skew_st_r;
  logic [1:0]    skew_cnt_r;
  logic          raw_de0_r;
  logic          raw_de1_r;
  logic [1:0]    skew_magnitude_r;
  logic          skew_sign_r;
  logic          skew_in_range_r;
  wire           rise0 = port0_pixel.de && !raw_de0_r;
  wire           rise1 = port1_pixel.de && !raw_de1_r;

  // A partner start that never comes within range marks the skew unmeasurable.
  always_ff @(posedge clk) begin
    if (srst) begin
      skew_st_r        <= SK_IDLE;
      skew_cnt_r       <= 2'h0;
      raw_de0_r        <= 1'b0;
      raw_de1_r        <= 1'b0;
      skew_magnitude_r <= 2'h0;
      skew_sign_r      <= 1'b0;
      skew_in_range_r  <= 1'b0;
    end else begin
      raw_de0_r <= port0_pixel.de;
      raw_de1_r <= port1_pixel.de;
      unique case (skew_st_r)
        SK_IDLE: begin
          skew_cnt_r <= 2'h1;
          if (rise0 && rise1) begin
            skew_magnitude_r <= 2'h0;
            skew_sign_r      <= 1'b0;
            skew_in_range_r  <= 1'b1;
          end else if (rise0) begin
            skew_st_r <= SK_P0_LEAD;
          end else if (rise1) begin
            skew_st_r <= SK_P1_LEAD;
          end
        end
        SK_P0_LEAD, SK_P1_LEAD: begin
          if ((skew_st_r == SK_P0_LEAD) ? rise1 : rise0) begin
            skew_magnitude_r <= skew_cnt_r;
            skew_sign_r      <= (skew_st_r == SK_P1_LEAD);
            skew_in_range_r  <= 1'b1;
            skew_st_r        <= SK_IDLE;
          end else if (skew_cnt_r == vbsr_pkg::SKEW_MAX) begin
            skew_in_range_r <= 1'b0;
            skew_st_r       <= SK_IDLE;
          end else begin
            skew_cnt_r <= skew_cnt_r + 2'h1;
          end
        end
      endcase
    end
  end

  wire dual_input_good = port0_active && port1_active && skew_in_range_r;

  // Serial link status arrives from the transmit clock domain; two flops per port.
  vbsr_pkg::vbsr_link_t link_meta_r [2];
  vbsr_pkg::vbsr_link_t link_sync_r [2];
  generate
    for (p = 0; p < 2; p++) begin : g_sync
      always_ff @(posedge clk) begin
        if (srst) begin
          link_meta_r[p] <= '0;
          link_sync_r[p] <= '0;
        end else begin
          link_meta_r[p] <= link_status_in[p];
          link_sync_r[p] <= link_meta_r[p];
        end
      end
    end
  endgenerate

  // Outside independent mode the status always describes port 0.
  wire                  sel_port = indep_mode_r && clk_mode_r[0];
  vbsr_pkg::vbsr_link_t sel_link;
  assign sel_link = link_sync_r[sel_port];
  wire serial_link_ready      = sel_link.link_ready;
  wire serial_transmit_active = sel_link.tx_active && sel_link.rx_locked
                                && sel_link.input_valid && sel_link.mode_ok;
  wire [1:0] serial_port_mode = serial_transmit_active ? sel_link.port_mode : vbsr_pkg::PMODE_IDLE;
  wire [7:0] link_byte = {serial_link_ready, serial_transmit_active, serial_port_mode,
                          sel_link.clk_detected, sel_link.pll_lock, sel_link.no_clock,
                          sel_link.freq_stable};

  // Read data mux; unmapped and write-only offsets read as zero.
  wire [7:0] skew_byte = {port1_input_lag_r, port0_input_lag_r, dual_input_good,
                          skew_sign_r, skew_magnitude_r};
  wire [7:0] rd_mux =
    (reg_addr == vbsr_pkg::ADDR_STEREO_ERR)  ? {5'h00, err_flags_r} :
    (reg_addr == vbsr_pkg::ADDR_SKEW_CTL)    ? skew_byte :
    (reg_addr == vbsr_pkg::ADDR_LINK_STS)    ? link_byte :
    (reg_addr == vbsr_pkg::ADDR_STEREO_MODE) ? {6'h00, stereo_mode_r} :
    (reg_addr == vbsr_pkg::ADDR_WIDTH_LO)    ? image_width_setting_r[7:0] :
    (reg_addr == vbsr_pkg::ADDR_WIDTH_HI)    ? {3'h0, image_width_setting_r[12:8]} :
    (reg_addr == vbsr_pkg::ADDR_IRQ_STS)     ? {5'h00, irq_sts_r} :
    (reg_addr == vbsr_pkg::ADDR_IRQ_EN)      ? {5'h00, irq_en_r} :
    (reg_addr == vbsr_pkg::ADDR_PORT_SEL)    ? {5'h00, indep_mode_r, clk_mode_r} :
    vbsr_pkg::RST_BYTE;

  // Interrupt status is sticky; an event beats a simultaneous clear.
  wire [2:0] irq_sts_nxt = (irq_sts_r & ~(reg_wdata[2:0] & {3{wr_irq_clr}})) | stereo_evt;
  wire       irq_nxt     = |(irq_sts_nxt & irq_en_r);

  // Software-visible registers.
  always_ff @(posedge clk) begin
    if (srst) begin
      err_flags_r           <= vbsr_pkg::RST_FLAGS;
      port0_input_lag_r     <= 2'h0;
      port1_input_lag_r     <= 2'h0;
      stereo_mode_r         <= vbsr_pkg::VBSR_MODE_OFF;
      image_width_setting_r <= vbsr_pkg::RST_WIDTH;
      irq_sts_r             <= vbsr_pkg::RST_FLAGS;
      irq_en_r              <= vbsr_pkg::RST_FLAGS;
      clk_mode_r            <= 2'h0;
      indep_mode_r          <= 1'b0;
      rdata_r               <= vbsr_pkg::RST_BYTE;
      irq_r                 <= 1'b0;
    end else begin
      err_flags_r <= err_flags_nxt;
      irq_sts_r   <= irq_sts_nxt;
      irq_r       <= irq_nxt;
      rdata_r     <= reg_rd ? rd_mux : vbsr_pkg::RST_BYTE;
      if (wr_skew) begin
        port1_input_lag_r <= reg_wdata[7:6];
        port0_input_lag_r <= reg_wdata[5:4];
      end
      if (wr_mode) begin
        stereo_mode_r <= vbsr_pkg::vbsr_mode_t'(reg_wdata[1:0]);
      end
      if (wr_wlo) begin
        image_width_setting_r[7:0] <= reg_wdata;
      end
      if (wr_whi) begin
        image_width_setting_r[12:8] <= reg_wdata[4:0];
      end
      if (wr_irq_en) begin
        irq_en_r <= reg_wdata[2:0];
      end
      if (wr_sel) begin
        clk_mode_r   <= reg_wdata[1:0];
        indep_mode_r <= reg_wdata[2];
      end
    end
  end

  assign reg_rdata = rdata_r;
  assign irq       = irq_r;

  // Checks on the stereo flags.
  a_read_clears_flags: assert property (rd_stereo && (stereo_evt == 3'h0) |=> err_flags_r == 3'h0)
    else $error("stereo flags not cleared by read");
  a_flags_hold_set: assert property (!rd_stereo |=> (err_flags_r & $past(err_flags_r)) == $past(err_flags_r))
    else $error("stereo flag dropped without a read");
  a_overflow_alt_line: assert property (line_end && mode_alt_line
      && line_len_r >= vbsr_pkg::LEN_LIMIT_ALT_LINE |=> err_flags_r[vbsr_pkg::FLAG_OVERFLOW])
    else $error("alternate-line overflow not flagged");
  a_overflow_wide_line: assert property (line_end && mode_sbs
      && line_len_r >= vbsr_pkg::LEN_LIMIT_WIDE |=> err_flags_r[vbsr_pkg::FLAG_OVERFLOW])
    else $error("wide-line overflow not flagged");
  a_read_returns_flags: assert property (rd_stereo |=> reg_rdata == {5'h00, $past(err_flags_r)})
    else $error("stereo flag read value wrong");
  a_sbs_mismatch_flag: assert property (line_end && mode_sbs && line_len_r == width_x2 + 14'h0002 |=> err_flags_r[0])
    else $error("side-by-side length mismatch missed");

  // Checks on the lag lines and skew measurement.
  // The zero-lag check skips the release edge, where the merged stream still shows its reset value.
  a_port1_lag_two: assert property (port1_input_lag_r == 2'h2 && $past(port1_input_lag_r) == 2'h2
      |-> merged_port1 == $past(port1_pixel, 3))
    else $error("port 1 lag of two pixel clocks wrong");
  a_port0_lag_zero: assert property (!srst && port0_input_lag_r == 2'h0
      |=> merged_port0 == $past(port0_pixel))
    else $error("port 0 zero lag wrong");
  a_skew_p1_lead: assert property (skew_st_r == SK_P1_LEAD && rise0 |=> skew_sign_r && skew_in_range_r)
    else $error("skew sign wrong when port 1 leads");
  a_skew_magnitude: assert property (skew_st_r == SK_P0_LEAD && rise1 |=> skew_magnitude_r == $past(skew_cnt_r))
    else $error("skew magnitude wrong");
  a_dual_good_read: assert property (reg_rd && reg_addr == vbsr_pkg::ADDR_SKEW_CTL
      |=> reg_rdata[3] == $past(port0_active && port1_active && skew_in_range_r))
    else $error("dual input good bit wrong");

  // Checks on the link status byte.
  a_tx_status_read: assert property (reg_rd && reg_addr == vbsr_pkg::ADDR_LINK_STS
      |=> reg_rdata[6] == $past(sel_link.tx_active && sel_link.rx_locked && sel_link.input_valid && sel_link.mode_ok))
    else $error("transmit status bit wrong");
  a_mode_when_idle: assert property (reg_rd && reg_addr == vbsr_pkg::ADDR_LINK_STS && !serial_transmit_active
      |=> reg_rdata[5:4] == 2'h0)
    else $error("port mode shown while transmitter idle");
  a_port_select: assert property (!indep_mode_r |-> sel_link == link_sync_r[0])
    else $error("status not from port 0 outside independent mode");
  a_link_ready_read: assert property (reg_rd && reg_addr == vbsr_pkg::ADDR_LINK_STS
      |=> reg_rdata[7] == $past(sel_link.link_ready))
    else $error("link ready bit wrong");
  a_port_mode_shown: assert property (reg_rd && reg_addr == vbsr_pkg::ADDR_LINK_STS && serial_transmit_active
      |=> reg_rdata[5:4] == $past(sel_link.port_mode))
    else $error("port mode not shown while transmitting");

  // Checks on event flags and the interrupt line; an enable change is let settle for one cycle.
  a_proc_error_flag: assert property (proc_evt |=> err_flags_r[vbsr_pkg::FLAG_PROC])
    else $error("processing error not flagged");
  a_alt_line_mismatch: assert property (mism_alt |=> err_flags_r[vbsr_pkg::FLAG_MISMATCH])
    else $error("alternate-line mismatch not flagged");
  a_irq_level: assert property ($stable(irq_en_r) |-> irq == |(irq_sts_r & irq_en_r))
    else $error("interrupt level wrong");

  c_flag_read: cover property (rd_stereo && err_flags_r != 3'h0);
  c_overflow: cover property (ovf_alt_line || ovf_wide);
  c_dual_good: cover property (dual_input_good && skew_magnitude_r == 2'h2);
  c_irq_raise: cover property (!irq ##1 irq);

endmodule // vbsr_status_regs

// ### verification/vbsr_video_src.sv
`timescale 1ns/10ps
// Stand-in for the video processor that drives both input ports.
module vbsr_video_src (
  input  wire logic             clk,
  output vbsr_pkg::vbsr_pixel_t port0_pixel,
  output vbsr_pkg::vbsr_pixel_t port1_pixel,
  output logic                  port0_active,
  output logic                  port1_active
);
  logic [23:0] cnt_r;

  // Both receivers start active with idle lines.
  initial begin
    port0_pixel  = '0;
    port1_pixel  = '0;
    port0_active = 1'b1;
    port1_active = 1'b1;
    cnt_r        = 24'h000000;
  end

  // Data changes every cycle, so a lane never repeats its last pixel by accident.
  always @(posedge clk) begin
    cnt_r            <= cnt_r + 24'h000001;
    port0_pixel.data <= cnt_r;
    port1_pixel.data <= ~cnt_r;
  end

  // One line on each port; a positive skew starts port 1 later, a negative one port 0.
  task automatic send_line(input int len, input int blank, input int skew);
    int s0;
    int s1;
    s0 = blank + ((skew < 0) ? -skew : 0);
    s1 = blank + ((skew > 0) ? skew : 0);
    for (int i = 0; i < ((s0 > s1) ? s0 : s1) + len + 1; i++) begin
      @(posedge clk);
      port0_pixel.de <= (i >= s0) && (i < s0 + len);
      port1_pixel.de <= (i >= s1) && (i < s1 + len);
    end
  endtask
endmodule // vbsr_video_src

// ### verification/vbsr_status_regs_tb_top.sv
`timescale 1ns/10ps
// Self-checking bench for the status register bank.
module vbsr_status_regs_tb_top;
  logic                  clk = 1'b0;
  logic                  srst;
  logic [7:0]            reg_addr;
  logic [7:0]            reg_wdata;
  logic                  reg_wr;
  logic                  reg_rd;
  logic [7:0]            reg_rdata;
  logic                  irq;
  vbsr_pkg::vbsr_pixel_t port0_pixel;
  vbsr_pkg::vbsr_pixel_t port1_pixel;
  logic                  port0_active;
  logic                  port1_active;
  vbsr_pkg::vbsr_pixel_t merged_port0;
  vbsr_pkg::vbsr_pixel_t merged_port1;
  vbsr_pkg::vbsr_link_t  link_status_in [2];
  vbsr_pkg::vbsr_pixel_t h0 [4];
  vbsr_pkg::vbsr_pixel_t h1 [4];
  int                    n_fail = 0;
  int                    tests_run = 0;

  vbsr_status_regs dut_u (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .port0_pixel(port0_pixel),
    .port1_pixel(port1_pixel), .port0_active(port0_active), .port1_active(port1_active),
    .merged_port0(merged_port0), .merged_port1(merged_port1), .link_status_in(link_status_in));

  vbsr_video_src src_u (.clk(clk), .port0_pixel(port0_pixel), .port1_pixel(port1_pixel),
    .port0_active(port0_active), .port1_active(port1_active));

  // Clock at 20 MHz.
  always #25 clk = ~clk;

  // History of what the ports presented, so the delayed streams can be predicted.
  always @(posedge clk) begin
    for (int k = 3; k > 0; k--) begin
      h0[k] <= h0[k-1];
      h1[k] <= h1[k-1];
    end
    h0[0] <= port0_pixel;
    h1[0] <= port1_pixel;
  end

  task automatic close_out();
    if (n_fail == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chkp(input string what, input vbsr_pkg::vbsr_pixel_t e, input vbsr_pkg::vbsr_pixel_t g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  // Bus cycles: one strobe cycle each, read data taken in the cycle after the strobe.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk8(what, e, reg_rdata & m);
  endtask

  // A line, then time for the flags to land behind the delayed stream.
  task automatic ln(input int len, input int blank, input int skew);
    src_u.send_line(len, blank, skew);
    repeat (8) @(posedge clk);
  endtask

  task automatic t_reset();
    rdc("error flags", 8'h58, 8'hFF, 8'h00);
    rdc("skew status", 8'h59, 8'hFF, 8'h00);
    wr(8'h5A, 8'hFF);
    rdc("link status", 8'h5A, 8'hFF, 8'h00);
    rdc("unmapped", 8'h99, 8'hFF, 8'h00);
  endtask

  // Boundary lengths per mode; the flag must outlive a good line and clear on read.
  task automatic t_overflow();
    wr(8'h65, 8'h04);
    wr(8'h60, 8'h01);
    ln(4095, 4, 0);
    rdc("overflow 4095", 8'h58, 8'h04, 8'h00);
    ln(4096, 4, 0);
    chk8("irq raised", 8'h01, {7'h00, irq});
    ln(10, 4, 0);
    rdc("overflow 4096", 8'h58, 8'h04, 8'h04);
    rdc("overflow cleared", 8'h58, 8'h04, 8'h00);
    wr(8'h60, 8'h02);
    ln(8191, 4, 0);
    rdc("overflow 8191", 8'h58, 8'h04, 8'h00);
    wr(8'h60, 8'h03);
    ln(8192, 4, 0);
    rdc("overflow 8192", 8'h58, 8'h04, 8'h04);
    rdc("irq status", 8'h63, 8'h04, 8'h04);
    wr(8'h64, 8'h04);
    rdc("irq status clear", 8'h63, 8'h04, 8'h00);
    chk8("irq dropped", 8'h00, {7'h00, irq});
  endtask

  task automatic t_mismatch();
    wr(8'h60, 8'h01);
    ln(10, 4, 0);
    ln(10, 4, 0);
    ln(10, 4, 0);
    rdc("three equal lines", 8'h58, 8'h07, 8'h00);
    ln(10, 4, 0);
    ln(10, 4, 0);
    rdc("equal lines", 8'h58, 8'h01, 8'h00);
    ln(12, 4, 0);
    ln(14, 4, 0);
    chk8("masked irq", 8'h00, {7'h00, irq});
    rdc("unequal lines", 8'h58, 8'h01, 8'h01);
    wr(8'h61, 8'h08);
    wr(8'h62, 8'h00);
    wr(8'h60, 8'h02);
    ln(16, 4, 0);
    rdc("first twice width", 8'h58, 8'h07, 8'h00);
    ln(16, 4, 0);
    rdc("twice width", 8'h58, 8'h01, 8'h00);
    ln(18, 4, 0);
    rdc("not twice width", 8'h58, 8'h01, 8'h01);
  endtask

  task automatic t_proc();
    wr(8'h60, 8'h01);
    ln(10, 4, 0);
    rdc("good blanking", 8'h58, 8'h02, 8'h00);
    // Back-to-back lines leave only two low cycles between them.
    src_u.send_line(10, 1, 0);
    ln(10, 1, 0);
    rdc("short blanking", 8'h58, 8'h02, 8'h02);
    wr(8'h60, 8'h03);
    ln(11, 4, 0);
    rdc("odd length", 8'h58, 8'h02, 8'h02);
    wr(8'h60, 8'h00);
  endtask

  // Port 1 and port 0 lags from the upper and lower field, both fields at once.
  task automatic t_lag();
    logic [7:0] v [2] = '{8'hB0, 8'h40};
    for (int j = 0; j < 2; j++) begin
      wr(8'h59, v[j]);
      repeat (5) @(posedge clk);
      fork
        src_u.send_line(6, 4, 0);
        repeat (12) begin
          @(negedge clk);
          chkp("port0 lag", h0[v[j][5:4]], merged_port0);
          chkp("port1 lag", h1[v[j][7:6]], merged_port1);
        end
      join
    end
    wr(8'h59, 8'h00);
  endtask

  task automatic t_skew();
    int         sk [4] = '{2, -3, 0, 5};
    logic [7:0] ex [4] = '{8'h0A, 8'h0F, 8'h08, 8'h00};
    logic [7:0] mk [4] = '{8'h0F, 8'h0F, 8'h0F, 8'h08};
    for (int j = 0; j < 4; j++) begin
      ln(10, 4, sk[j]);
      rdc("skew", 8'h59, mk[j], ex[j]);
    end
    @(posedge clk);
    src_u.port1_active <= 1'b0;
    ln(10, 4, 0);
    rdc("one port idle", 8'h59, 8'h08, 8'h00);
    @(posedge clk);
    src_u.port1_active <= 1'b1;
  endtask

  // Selected port follows the clock mode field only in independent mode.
  task automatic t_link();
    logic [7:0]  sel [4] = '{8'h04, 8'h05, 8'h01, 8'h05};
    logic [10:0] p1  [4] = '{11'h3E5, 11'h3E5, 11'h3E5, 11'h3A5};
    logic [7:0]  ex  [4] = '{8'hDA, 8'h65, 8'hDA, 8'h05};
    for (int j = 0; j < 4; j++) begin
      @(posedge clk);
      link_status_in[0] <= 11'h7DA;
      link_status_in[1] <= p1[j];
      wr(8'h66, sel[j]);
      repeat (4) @(posedge clk);
      rdc("link status", 8'h5A, 8'hFF, ex[j]);
    end
  endtask

  // Main sequence after a five-cycle reset.
  initial begin
    srst              = 1'b1;
    reg_addr          = 8'h00;
    reg_wdata         = 8'h00;
    reg_wr            = 1'b0;
    reg_rd            = 1'b0;
    link_status_in[0] = '0;
    link_status_in[1] = '0;
    for (int k = 0; k < 4; k++) begin
      h0[k] = '0;
      h1[k] = '0;
    end
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_overflow();
    t_mismatch();
    t_proc();
    t_lag();
    t_skew();
    t_link();
    close_out();
  end

  // Watchdog sized well above the roughly 25000 cycles the sequence needs.
  initial begin
    repeat (80000) @(posedge clk);
    n_fail++;
    close_out();
  end
endmodule // vbsr_status_regs_tb_top
